/* iefc_pkg.sv */
// constants and carrier types for the interrupt enable and flag control block
package iefc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CORE_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_PERIPH_EN = 4'h1;
   localparam logic [DATA_W-1:0] CORE_CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] PERIPH_EN_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

   // ------------------------------------------------------------
   // core control field positions
   // ------------------------------------------------------------
   localparam int GLOBAL_EN_BIT = 7;
   localparam int GROUP_EN_BIT = 6;
   localparam int T8IE_BIT = 5;
   localparam int EXTIE_BIT = 4;
   localparam int PCIE_BIT = 3;
   localparam int T8IF_BIT = 2;
   localparam int EXTIF_BIT = 1;
   localparam int PCIF_BIT = 0;
   localparam int SYNC_STAGES = 3;

   // ------------------------------------------------------------
   // dispatch
   // ------------------------------------------------------------
   localparam int PC_W = 15;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic write;
      logic read;
   } iefc_bus_req_t;

   typedef struct packed {
      logic flush_prefetch;
      logic push_pc;
      logic save_context;
      logic load_vector;
   } iefc_dispatch_t;

   typedef struct packed {
      logic pop_pc;
      logic restore_context;
   } iefc_return_t;

   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_SERVICE = 1'b1
   } iefc_state_t;

endpackage

/* iefc_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module iefc_sync
   import iefc_pkg::*;
#(
   parameter int STAGES = 3
)
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic async_in,
   output logic level_out
);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   if (STAGES != 3)
   begin : g_bad_stages
      $error("iefc_sync supports exactly three stages");
   end

   logic [STAGES-1:0] chain;

   // ------------------------------------------------------------
   // chain; first stage only feeds the second
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         chain <= '0;
      end
      else
      begin
         chain <= {chain[STAGES-2:0], async_in};
      end
   end

   // level moves only once second and third stage agree
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         level_out <= 1'b0;
      end
      else if (chain[1] == chain[2])
      begin
         level_out <= chain[2];
      end
   end

endmodule

/* iefc_edge.sv */
// selectable edge detector producing a one-cycle pulse
`timescale 1ns/1ps
module iefc_edge
   import iefc_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic level_in,
   input wire logic rising_sel_in,
   output logic pulse_out
);

   logic level_q;
   logic next_pulse;

   always_comb
   begin
      if (rising_sel_in)
      begin
         next_pulse = level_in & ~level_q;
      end
      else
      begin
         next_pulse = ~level_in & level_q;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         level_q <= 1'b0;
         pulse_out <= 1'b0;
      end
      else
      begin
         level_q <= level_in;
         pulse_out <= next_pulse;
      end
   end

endmodule

/* iefc_top.sv */
// interrupt enable, flag and request control for the processor core
`timescale 1ns/1ps
// Operation
// - global enable bit 7 passes active sources when set, blocks everything when clear
// - peripheral group enable bit 6 gates every peripheral-register source
// - bit 5 enables the 8-bit timer overflow request
// - bit 4 enables the external edge pin request
// - bit 3 enables the combined pin-change request, blocks it when clear
// - bit 2 flag sets on 8-bit timer overflow or on a software write of one
// - bit 1 flag sets on a qualifying external pin edge
// - bit 0 reads one when any per-pin change flag is set
// - pin-change summary is read-only, clears once all per-pin flags clear
// - flags set on their condition regardless of any enable
// - bits 7..1 read/write, bit 0 read-only, both registers reset to zero
// - peripheral enable bit 7 enables 16-bit timer gate acquisition request
// - peripheral enable bit 6 enables converter done request
// - peripheral enable bit 5 enables serial receive request
// - peripheral enable bit 4 enables serial transmit request
// - peripheral enable bit 3 enables synchronous serial request
// - peripheral enable bit 2 enables first capture/compare request
// - peripheral enable bit 1 enables period timer match request
// - peripheral enable bit 0 enables 16-bit timer overflow request
// - accepted interrupt flushes, clears global enable, pushes, saves, jumps to vector
// - return instruction pops, restores context and sets global enable, unless an interrupt is taken in the same cycle
// - edge select high means rising edge sets pin flag, low means falling
module iefc_top
   import iefc_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire iefc_bus_req_t bus_req_in,
   output logic [DATA_W-1:0] rd_data_out,
   input wire logic timer8_overflow_in,
   input wire logic ext_pin_in,
   input wire logic ext_pin_edge_select_in,
   input wire logic [DATA_W-1:0] per_pin_change_flags_in,
   input wire logic [DATA_W-1:0] periph_flags_in,
   input wire logic instr_boundary_in,
   input wire logic return_from_irq_instr_in,
   output logic irq_request_out,
   output iefc_dispatch_t dispatch_out,
   output logic [PC_W-1:0] vector_addr_out,
   output iefc_return_t return_out,
   output logic in_service_out,
   output logic global_irq_enable_out
);

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      addr_hit = (a == off);
   endfunction

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic global_irq_enable;
   logic peripheral_group_enable;
   logic timer8_overflow_enable;
   logic ext_pin_irq_enable;
   logic pin_change_enable;
   logic timer8_overflow_flag;
   logic ext_pin_irq_flag;
   logic pin_change_summary_flag;
   logic [DATA_W-1:0] peripheral_irq_enable_one;
   iefc_state_t state;
   logic ext_pin_level;
   logic ext_pin_edge;
   logic ctrl_write;
   logic periph_write;
   logic core_any;
   logic periph_any;
   logic next_request;
   logic take_irq;
   logic [DATA_W-1:0] core_irq_control;
   logic [DATA_W-1:0] next_rd_data;

   assign ctrl_write = bus_req_in.write && addr_hit(bus_req_in.addr, ADDR_CORE_CTRL);
   assign periph_write = bus_req_in.write && addr_hit(bus_req_in.addr, ADDR_PERIPH_EN);

   // ------------------------------------------------------------
   // external pin path
   // ------------------------------------------------------------
   iefc_sync #(
      .STAGES(SYNC_STAGES)
   ) u_pin_sync (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .async_in(ext_pin_in),
      .level_out(ext_pin_level)
   );

   iefc_edge u_pin_edge (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .level_in(ext_pin_level),
      .rising_sel_in(ext_pin_edge_select_in),
      .pulse_out(ext_pin_edge)
   );

   // ------------------------------------------------------------
   // enables
   // ------------------------------------------------------------
   // dispatch clears before any software write, return sets
   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         global_irq_enable <= CORE_CTRL_RESET[GLOBAL_EN_BIT];
      end
      else if (take_irq)
      begin
         global_irq_enable <= 1'b0;
      end
      else if (return_from_irq_instr_in)
      begin
         global_irq_enable <= 1'b1;
      end
      else if (ctrl_write)
      begin
         global_irq_enable <= bus_req_in.wdata[GLOBAL_EN_BIT];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         peripheral_group_enable <= CORE_CTRL_RESET[GROUP_EN_BIT];
         timer8_overflow_enable <= CORE_CTRL_RESET[T8IE_BIT];
         ext_pin_irq_enable <= CORE_CTRL_RESET[EXTIE_BIT];
         pin_change_enable <= CORE_CTRL_RESET[PCIE_BIT];
      end
      else if (ctrl_write)
      begin
         peripheral_group_enable <= bus_req_in.wdata[GROUP_EN_BIT];
         timer8_overflow_enable <= bus_req_in.wdata[T8IE_BIT];
         ext_pin_irq_enable <= bus_req_in.wdata[EXTIE_BIT];
         pin_change_enable <= bus_req_in.wdata[PCIE_BIT];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         peripheral_irq_enable_one <= PERIPH_EN_RESET;
      end
      else if (periph_write)
      begin
         peripheral_irq_enable_one <= bus_req_in.wdata;
      end
   end

   // ------------------------------------------------------------
   // flags; a hardware event wins over a software clear
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer8_overflow_flag <= CORE_CTRL_RESET[T8IF_BIT];
      end
      else if (timer8_overflow_in)
      begin
         timer8_overflow_flag <= 1'b1;
      end
      else if (ctrl_write)
      begin
         timer8_overflow_flag <= bus_req_in.wdata[T8IF_BIT];
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_pin_irq_flag <= CORE_CTRL_RESET[EXTIF_BIT];
      end
      else if (ext_pin_edge)
      begin
         ext_pin_irq_flag <= 1'b1;
      end
      else if (ctrl_write)
      begin
         ext_pin_irq_flag <= bus_req_in.wdata[EXTIF_BIT];
      end
   end

   // summary follows the per-pin flags only, writes do not reach it
   assign pin_change_summary_flag = |per_pin_change_flags_in;

   // ------------------------------------------------------------
   // request combine
   // ------------------------------------------------------------
   always_comb
   begin
      core_any = (timer8_overflow_flag & timer8_overflow_enable)
         | (ext_pin_irq_flag & ext_pin_irq_enable)
         | (pin_change_summary_flag & pin_change_enable);
      periph_any = |(periph_flags_in & peripheral_irq_enable_one);
      next_request = global_irq_enable & (core_any | (peripheral_group_enable & periph_any));
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_request_out <= 1'b0;
      end
      else
      begin
         irq_request_out <= next_request;
      end
   end

   // ------------------------------------------------------------
   // dispatch and return
   // ------------------------------------------------------------
   assign take_irq = irq_request_out && global_irq_enable && instr_boundary_in;

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dispatch_out <= '0;
         vector_addr_out <= PC_RESET;
      end
      else
      begin
         dispatch_out <= {4{take_irq}};
         if (take_irq)
         begin
            vector_addr_out <= IRQ_VECTOR;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         return_out <= '0;
      end
      else
      begin
         return_out <= {2{return_from_irq_instr_in}};
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_RUN;
      end
      else
      begin
         unique case (state)
            ST_RUN:
            begin
               if (take_irq)
               begin
                  state <= ST_SERVICE;
               end
            end
            ST_SERVICE:
            begin
               if (return_from_irq_instr_in)
               begin
                  state <= ST_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_service_out <= 1'b0;
         global_irq_enable_out <= 1'b0;
      end
      else
      begin
         in_service_out <= (state == ST_SERVICE);
         global_irq_enable_out <= global_irq_enable;
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------
   always_comb
   begin
      core_irq_control = {global_irq_enable, peripheral_group_enable, timer8_overflow_enable,
         ext_pin_irq_enable, pin_change_enable, timer8_overflow_flag, ext_pin_irq_flag,
         pin_change_summary_flag};
      next_rd_data = READ_UNMAPPED;
      if (addr_hit(bus_req_in.addr, ADDR_CORE_CTRL))
      begin
         next_rd_data = core_irq_control;
      end
      else if (addr_hit(bus_req_in.addr, ADDR_PERIPH_EN))
      begin
         next_rd_data = peripheral_irq_enable_one;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data_out <= READ_UNMAPPED;
      end
      else if (bus_req_in.read)
      begin
         rd_data_out <= next_rd_data;
      end
      else
      begin
         rd_data_out <= READ_UNMAPPED;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_n);

   sequence s_pin_rise;
      $rose(ext_pin_in) && ext_pin_edge_select_in;
   endsequence

   sequence s_pin_quiet;
      (ext_pin_in && ext_pin_edge_select_in && !ctrl_write)[*6];
   endsequence

   sequence s_take;
      irq_request_out && global_irq_enable && instr_boundary_in;
   endsequence

   property p_gie_blocks;
      !global_irq_enable |=> !irq_request_out;
   endproperty
   a_gie_blocks: assert property (p_gie_blocks) else $error("request while global enable clear");

   property p_group_gate;
      (!peripheral_group_enable && !core_any) |=> !irq_request_out;
   endproperty
   a_group_gate: assert property (p_group_gate) else $error("peripheral request passed closed group");

   property p_timer_request;
      (global_irq_enable && timer8_overflow_enable && timer8_overflow_flag) |=> irq_request_out;
   endproperty
   a_timer_request: assert property (p_timer_request) else $error("timer request missing");

   property p_pin_change_gate;
      (global_irq_enable && !pin_change_enable && pin_change_summary_flag && !peripheral_group_enable
         && !(timer8_overflow_flag && timer8_overflow_enable) && !(ext_pin_irq_flag && ext_pin_irq_enable))
         |=> !irq_request_out;
   endproperty
   a_pin_change_gate: assert property (p_pin_change_gate) else $error("pin change passed while disabled");

   property p_timer_flag;
      timer8_overflow_in |=> timer8_overflow_flag;
   endproperty
   a_timer_flag: assert property (p_timer_flag) else $error("overflow did not set flag");

   property p_pin_flag;
      s_pin_rise ##1 s_pin_quiet |-> ext_pin_irq_flag;
   endproperty
   a_pin_flag: assert property (p_pin_flag) else $error("rising pin edge not flagged");

   property p_summary_read;
      (bus_req_in.read && addr_hit(bus_req_in.addr, ADDR_CORE_CTRL))
         |=> rd_data_out[PCIF_BIT] == $past(pin_change_summary_flag);
   endproperty
   a_summary_read: assert property (p_summary_read) else $error("summary flag read mismatch");

   property p_periph_request;
      (global_irq_enable && peripheral_group_enable && |(periph_flags_in & peripheral_irq_enable_one))
         |=> irq_request_out;
   endproperty
   a_periph_request: assert property (p_periph_request) else $error("peripheral request missing");

   property p_dispatch;
      s_take |=> (!global_irq_enable && (&dispatch_out) && vector_addr_out == IRQ_VECTOR) ##1 in_service_out;
   endproperty
   a_dispatch: assert property (p_dispatch) else $error("dispatch sequence wrong");

   property p_return;
      (return_from_irq_instr_in && !take_irq) |=> global_irq_enable && (&return_out);
   endproperty
   a_return: assert property (p_return) else $error("return did not restore enable");

endmodule

/* iefc_core_model.sv */
// processor core stand-in facing the interrupt control block
`timescale 1ns/1ps
module iefc_core_model
   import iefc_pkg::*;
#(
   parameter int GAP = 3,
   parameter int RET_DLY = 20
)
(
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   input wire logic accept_en_in,
   input wire logic in_service_in,
   output logic instr_boundary_out,
   output logic return_pulse_out
);
   int phase;
   int busy;

   // ------------------------------------------------------------
   // boundaries only every GAP+1 cycles, like a slow core
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         phase <= 0;
         instr_boundary_out <= 1'b0;
      end
      else
      begin
         phase <= (phase == GAP) ? 0 : phase + 1;
         instr_boundary_out <= accept_en_in && (phase == GAP);
      end
   end

   // ------------------------------------------------------------
   // service routine ends after RET_DLY cycles in service
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         busy <= 0;
         return_pulse_out <= 1'b0;
      end
      else
      begin
         busy <= (in_service_in && busy < RET_DLY) ? busy + 1 : 0;
         return_pulse_out <= in_service_in && (busy == RET_DLY - 1);
      end
   end
endmodule

/* tb_iefc_top.sv */
// self-checking bench for the interrupt enable and flag control block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module tb_iefc_top
   import iefc_pkg::*;
;
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] d;
      logic [7:0] pf;
      logic [7:0] q;
      logic irq;
   } iefc_row_t;
   iefc_row_t rows [9] = '{
      '{4'h1, 8'hff, 8'h00, 8'hff, 1'b0}, '{4'h1, 8'h00, 8'h00, 8'h00, 1'b0},
      '{4'h0, 8'h7f, 8'h00, 8'h7e, 1'b0}, '{4'h0, 8'h40, 8'h01, 8'h40, 1'b0},
      '{4'h1, 8'h01, 8'h01, 8'h01, 1'b0}, '{4'h0, 8'hc0, 8'h01, 8'hc0, 1'b1},
      '{4'h0, 8'h80, 8'h01, 8'h80, 1'b0}, '{4'h0, 8'hc0, 8'h01, 8'hc0, 1'b1},
      '{4'h5, 8'hff, 8'h01, 8'h00, 1'b1}};
   logic core_clk_in, reset_n_in, t8, pin, sel, boundary, ret, acc_en;
   logic [7:0] ppc, pf, rdata;
   iefc_bus_req_t bus;
   logic irq, in_svc, g_en;
   iefc_dispatch_t disp;
   iefc_return_t rtn;
   logic [PC_W-1:0] vec;
   int n_errors = 0;
   int n_compared = 0;
   int n_disp = 0;
   int n_ret = 0;

   iefc_top DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .bus_req_in(bus),
      .rd_data_out(rdata), .timer8_overflow_in(t8), .ext_pin_in(pin), .ext_pin_edge_select_in(sel),
      .per_pin_change_flags_in(ppc), .periph_flags_in(pf), .instr_boundary_in(boundary),
      .return_from_irq_instr_in(ret), .irq_request_out(irq), .dispatch_out(disp),
      .vector_addr_out(vec), .return_out(rtn), .in_service_out(in_svc), .global_irq_enable_out(g_en));
   iefc_core_model core (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .accept_en_in(acc_en),
      .in_service_in(in_svc), .instr_boundary_out(boundary), .return_pulse_out(ret));

   initial
   begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end

   // ------------------------------------------------------------
   // bus tasks and waits
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_in) bus <= {a, d, 2'b10};
      @(posedge core_clk_in) bus <= '0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] q);
      @(posedge core_clk_in) bus <= {a, 8'h00, 2'b01};
      @(posedge core_clk_in) bus <= '0;
      #1 `CHK(rdata, q);
   endtask

   task automatic settle();
      repeat (2) @(posedge core_clk_in);
      #1;
   endtask

   task automatic pin_step(input logic v, input logic s, input logic [7:0] q);
      @(posedge core_clk_in) pin <= v;
      sel <= s;
      repeat (10) @(posedge core_clk_in);
      rd(4'h0, q);
   endtask

   task automatic wait_on(input bit for_en);
      for (int k = 0; k < 100; k++)
      begin
         @(posedge core_clk_in);
         if ((for_en ? g_en : in_svc) === 1'b1)
            return;
      end
      n_errors++;
      $display("ERROR %0t: wait expired", $time);
      wrap_up();
   endtask

   task automatic wrap_up();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // dispatch and return monitor
   // ------------------------------------------------------------
   always @(posedge core_clk_in)
   begin
      if (disp.flush_prefetch === 1'b1)
      begin
         n_disp++;
         `CHK(disp, 4'hf);
         `CHK(vec, 15'h0004);
         `CHK(g_en, 1'b1);
      end
      if (rtn.pop_pc === 1'b1)
      begin
         n_ret++;
         `CHK(rtn, 2'b11);
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      reset_n_in = 1'b0;
      bus = '0;
      {t8, pin, sel, acc_en} = 4'h0;
      ppc = 8'h00;
      pf = 8'h00;
      repeat (8) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      foreach (rows[i])
      begin
         @(posedge core_clk_in) pf <= rows[i].pf;
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].q);
         `CHK(irq, rows[i].irq);
      end
      // each peripheral enable against its own flag and all others
      for (int i = 0; i < 8; i++)
      begin
         @(posedge core_clk_in) pf <= 8'h01 << i;
         wr(4'h1, 8'h01 << i);
         settle();
         `CHK(irq, 1'b1);
         @(posedge core_clk_in) pf <= ~(8'h01 << i);
         settle();
         `CHK(irq, 1'b0);
      end
      wr(4'h0, 8'h00);
      pin_step(1'b1, 1'b1, 8'h02);
      wr(4'h0, 8'h00);
      pin_step(1'b0, 1'b1, 8'h00);
      pin_step(1'b1, 1'b0, 8'h00);
      pin_step(1'b0, 1'b0, 8'h02);
      wr(4'h0, 8'h92);
      settle();
      `CHK(irq, 1'b1);
      @(posedge core_clk_in) ppc <= 8'h10;
      wr(4'h0, 8'h00);
      rd(4'h0, 8'h01);
      wr(4'h0, 8'h88);
      settle();
      `CHK(irq, 1'b1);
      wr(4'h0, 8'h80);
      settle();
      `CHK(irq, 1'b0);
      @(posedge core_clk_in) ppc <= 8'h00;
      rd(4'h0, 8'h80);
      wr(4'h0, 8'h20);
      @(posedge core_clk_in) t8 <= 1'b1;
      @(posedge core_clk_in) t8 <= 1'b0;
      rd(4'h0, 8'h24);
      @(posedge core_clk_in) acc_en <= 1'b1;
      wr(4'h0, 8'ha4);
      wait_on(1'b0);
      #1 `CHK(g_en, 1'b0);
      wr(4'h0, 8'h20);
      wait_on(1'b1);
      settle();
      `CHK(n_disp, 1);
      `CHK(n_ret, 1);
      `CHK(irq, 1'b0);
      rd(4'h0, 8'ha0);
      @(posedge core_clk_in) acc_en <= 1'b0;
      pf <= 8'h80;
      wr(4'h0, 8'hc0);
      settle();
      `CHK(irq, 1'b1);
      @(posedge core_clk_in) reset_n_in <= 1'b0;
      #5 `CHK(irq, 1'b0);
      `CHK(g_en, 1'b0);
      repeat (8) @(posedge core_clk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h00);
      wrap_up();
   end
endmodule
